// File: core/frt_pkg.sv
/*
 holds constants and port bundles for the free running timer core.
 assumes a single cpu clock domain and a byte wide peripheral access port.
*/
package frt_pkg;
    localparam logic [15:0] count_reset_value = 16'hFFFC;
    localparam logic [15:0] count_wrap_value = 16'hFFFF;
    localparam logic [1:0] clk_sel_div2 = 2'h0;
    localparam logic [1:0] clk_sel_div4 = 2'h1;
    localparam logic [1:0] clk_sel_div8 = 2'h2;
    localparam logic [1:0] clk_sel_ext = 2'h3;
    localparam int prescale_width = 3;
    localparam logic [2:0] presc_reset_value = 3'h0;
    localparam int status_wrap_bit = 5;
    localparam logic [7:0] status_reserved = 8'h00;

    typedef enum logic [2:0] {
        sel_none,
        sel_count_high,
        sel_count_low,
        sel_alt_high,
        sel_alt_low,
        sel_status
    } reg_sel_t;

    typedef struct packed {
        logic rd;
        logic wr;
        reg_sel_t sel;
    } access_t;

    typedef struct packed {
        logic [1:0] clk_select_field;
        logic ext_clk_edge_select;
        logic wrap_irq_enable;
    } timer_cfg_t;
endpackage

// File: core/free_running_timer_counter.sv
/*
 free running timer counting core: prescaler, external clock, two count views,
 low byte buffer, wrap flag with two step clear, interrupt request.
 assumes the cpu drives one access per cycle as a one cycle strobe and that
 rdata is sampled the cycle after the strobe.
*/
`timescale 1ns/10ps
`default_nettype none
module free_running_timer_counter #(
    parameter bit ext_pin_bonded = 1'b1
) (
    input wire logic clk,
    input wire logic rst,
    input wire frt_pkg::access_t access,
    input wire frt_pkg::timer_cfg_t cfg,
    input wire logic cpu_irq_mask,
    input wire logic halt_mode,
    input wire logic ext_timer_clock_pin,
    output logic [7:0] rdata,
    output logic [15:0] count_value,
    output logic wrap_flag,
    output logic timer_tick,
    output logic wrap_irq
);
    import frt_pkg::*;

    // ----------------------------------------
    // view decoding
    // ----------------------------------------
    function automatic logic is_low_view(input reg_sel_t sel);
        return sel == sel_count_low || sel == sel_alt_low;
    endfunction

    function automatic logic is_high_view(input reg_sel_t sel);
        return sel == sel_count_high || sel == sel_alt_high;
    endfunction

    function automatic logic [2:0] divide_mask(input logic [1:0] field);
        logic [2:0] mask;
        mask = 3'h7;
        if (field == clk_sel_div2)
            mask = 3'h1;
        else if (field == clk_sel_div4)
            mask = 3'h3;
        return mask;
    endfunction

    // ----------------------------------------
    // external clock synchroniser
    // ----------------------------------------
    logic pin_in;
    logic sync_a;
    logic sync_b;
    logic sync_prev;

    assign pin_in = ext_pin_bonded ? ext_timer_clock_pin : 1'b1;

    always_ff @(posedge clk)
    begin
        if (rst)
            sync_a <= 1'b1;
        else
            sync_a <= pin_in;
    end

    always_ff @(posedge clk)
    begin
        if (rst)
            sync_b <= 1'b1;
        else
            sync_b <= sync_a;
    end

    always_ff @(posedge clk)
    begin
        if (rst)
            sync_prev <= 1'b1;
        else
            sync_prev <= sync_b;
    end

    // ----------------------------------------
    // external edge detection
    // ----------------------------------------
    logic rise_seen;
    logic fall_seen;
    logic ext_tick;

    assign rise_seen = sync_b && !sync_prev;
    assign fall_seen = !sync_b && sync_prev;
    assign ext_tick = cfg.ext_clk_edge_select ? rise_seen : fall_seen;

    // ----------------------------------------
    // prescaler
    // ----------------------------------------
    logic running;
    logic [2:0] presc;
    logic [2:0] next_presc;
    logic [2:0] presc_mask;
    logic int_tick;

    assign running = !halt_mode;
    assign next_presc = presc + 3'h1;
    assign presc_mask = divide_mask(cfg.clk_select_field);
    assign int_tick = (next_presc & presc_mask) == 3'h0;

    always_ff @(posedge clk)
    begin
        if (rst)
            presc <= presc_reset_value;
        else if (running)
            presc <= next_presc;
    end

    // ----------------------------------------
    // tick selection
    // ----------------------------------------
    logic use_ext;

    assign use_ext = cfg.clk_select_field == clk_sel_ext;
    assign timer_tick = running && (use_ext ? ext_tick : int_tick);

    // ----------------------------------------
    // access decode
    // ----------------------------------------
    logic main_low_access;
    logic low_write;
    logic high_read;
    logic low_read;
    logic status_read;

    assign main_low_access = (access.rd || access.wr) && access.sel == sel_count_low;
    assign low_write = access.wr && is_low_view(access.sel);
    assign high_read = access.rd && is_high_view(access.sel);
    assign low_read = access.rd && is_low_view(access.sel);
    assign status_read = access.rd && access.sel == sel_status;

    // ----------------------------------------
    // wrap detection
    // ----------------------------------------
    logic at_wrap;
    logic wrap_event;

    assign at_wrap = count_value == count_wrap_value;
    assign wrap_event = timer_tick && at_wrap && !low_write;

    // ----------------------------------------
    // counter
    // ----------------------------------------
    logic [15:0] next_count;

    assign next_count = low_write ? count_reset_value :
                        timer_tick ? count_value + 16'h0001 :
                        count_value;

    always_ff @(posedge clk)
    begin
        if (rst)
            count_value <= count_reset_value;
        else
            count_value <= next_count;
    end

    // ----------------------------------------
    // two byte read sequence
    // ----------------------------------------
    typedef enum {
        seq_live,
        seq_held
    } read_seq_t;

    read_seq_t seq;
    read_seq_t next_seq;
    logic capture_low;

    assign capture_low = high_read && seq == seq_live;

    always_comb
    begin
        next_seq = seq;
        unique case (seq)
            seq_live:
            begin
                if (high_read)
                    next_seq = seq_held;
            end
            seq_held:
            begin
                if (low_read)
                    next_seq = seq_live;
            end
        endcase
    end

    always_ff @(posedge clk)
    begin
        if (rst)
            seq <= seq_live;
        else
            seq <= next_seq;
    end

    // ----------------------------------------
    // low byte buffer
    // ----------------------------------------
    logic [7:0] low_buffer;

    always_ff @(posedge clk)
    begin
        if (rst)
            low_buffer <= 8'h00;
        else if (capture_low)
            low_buffer <= count_value[7:0];
    end

    // ----------------------------------------
    // clear sequence
    // ----------------------------------------
    typedef enum {
        clr_idle,
        clr_armed
    } clear_seq_t;

    clear_seq_t clr_state;
    clear_seq_t next_clr_state;
    logic arm_clear;
    logic drop_clear;
    logic clear_now;

    assign arm_clear = status_read && wrap_flag;
    assign drop_clear = main_low_access || !wrap_flag;
    assign clear_now = clr_state == clr_armed && main_low_access;

    always_comb
    begin
        next_clr_state = clr_state;
        unique case (clr_state)
            clr_idle:
            begin
                if (arm_clear)
                    next_clr_state = clr_armed;
            end
            clr_armed:
            begin
                if (!arm_clear && drop_clear)
                    next_clr_state = clr_idle;
            end
        endcase
    end

    always_ff @(posedge clk)
    begin
        if (rst)
            clr_state <= clr_idle;
        else
            clr_state <= next_clr_state;
    end

    // ----------------------------------------
    // wrap flag
    // ----------------------------------------
    logic next_wrap_flag;

    assign next_wrap_flag = wrap_event ? 1'b1 :
                            clear_now ? 1'b0 :
                            wrap_flag;

    always_ff @(posedge clk)
    begin
        if (rst)
            wrap_flag <= 1'b0;
        else
            wrap_flag <= next_wrap_flag;
    end

    // ----------------------------------------
    // interrupt request
    // ----------------------------------------
    assign wrap_irq = wrap_flag && cfg.wrap_irq_enable && !cpu_irq_mask;

    // ----------------------------------------
    // status byte
    // ----------------------------------------
    logic [7:0] status_byte;

    assign status_byte = status_reserved | (8'(wrap_flag) << status_wrap_bit);

    // ----------------------------------------
    // read data
    // ----------------------------------------
    logic [7:0] low_byte_view;
    logic [7:0] next_rdata;

    assign low_byte_view = (seq == seq_held) ? low_buffer : count_value[7:0];
    assign next_rdata = is_high_view(access.sel) ? count_value[15:8] :
                        is_low_view(access.sel) ? low_byte_view :
                        (access.sel == sel_status) ? status_byte : 8'h00;

    always_ff @(posedge clk)
    begin
        if (rst)
            rdata <= 8'h00;
        else if (access.rd)
            rdata <= next_rdata;
    end
endmodule
`default_nettype wire

// File: dv/frt_ext_clock_src.sv
/* external timer clock source model.
 assumes run is driven off the cpu clock edge. */
`timescale 1ns/10ps
`default_nettype none
module frt_ext_clock_src (
    input wire logic clk,
    input wire logic run,
    output logic pin
);
    logic [1:0] cnt = 2'h0;
    initial pin = 1'b0;
    // toggles every four cpu clocks, still between frames
    always @(posedge clk)
        if (run)
        begin
            cnt <= cnt + 2'h1;
            if (cnt == 2'h3) pin <= ~pin;
        end
endmodule
`default_nettype wire

// File: dv/free_running_timer_counter_monitor.sv
/* port assertions for the timer core.
 assumes it is bound to every core instance. */
`timescale 1ns/10ps
`default_nettype none
module free_running_timer_counter_monitor (
    input wire logic clk,
    input wire logic rst,
    input wire frt_pkg::access_t access,
    input wire frt_pkg::timer_cfg_t cfg,
    input wire logic cpu_irq_mask,
    input wire logic halt_mode,
    input wire logic [7:0] rdata,
    input wire logic [15:0] count_value,
    input wire logic wrap_flag,
    input wire logic timer_tick,
    input wire logic wrap_irq
);
    import frt_pkg::*;
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    wire wr_low = access.wr && (access.sel == sel_count_low || access.sel == sel_alt_low);
    property p_irq; wrap_irq == (wrap_flag && cfg.wrap_irq_enable && !cpu_irq_mask); endproperty
    a_irq: assert property (p_irq) else $error("irq");
    property p_rst; disable iff (1'b0) rst |=> count_value == 16'hFFFC && !wrap_flag; endproperty
    a_rst: assert property (p_rst) else $error("rst");
    property p_wr; wr_low |=> count_value == 16'hFFFC; endproperty
    a_wr: assert property (p_wr) else $error("wr");
    property p_inc;
        timer_tick && !wr_low |=> count_value == $past(count_value) + 16'h0001;
    endproperty
    a_inc: assert property (p_inc) else $error("inc");
    property p_wrap; timer_tick && count_value == 16'hFFFF && !wr_low |=> wrap_flag; endproperty
    a_wrap: assert property (p_wrap) else $error("wrap");
    property p_halt; halt_mode |-> !timer_tick; endproperty
    a_halt: assert property (p_halt) else $error("halt");
    property p_alt; access.rd && access.sel == sel_alt_low && wrap_flag |=> wrap_flag; endproperty
    a_alt: assert property (p_alt) else $error("alt");
    property p_stat;
        access.rd && access.sel == sel_status |=> rdata == {2'h0, $past(wrap_flag), 5'h00};
    endproperty
    a_stat: assert property (p_stat) else $error("stat");
    cover property (wrap_flag ##1 !wrap_flag);
    cover property (timer_tick && cfg.clk_select_field == clk_sel_ext);
    cover property (wrap_irq);
endmodule
bind free_running_timer_counter free_running_timer_counter_monitor mon (.clk, .rst, .access,
    .cfg, .cpu_irq_mask, .halt_mode, .rdata, .count_value, .wrap_flag, .timer_tick, .wrap_irq);
`default_nettype wire

// File: dv/tb_free_running_timer_counter.sv
/* self-checking bench for the timer core.
 assumes the package and core compile first. */
`timescale 1ns/10ps
`default_nettype none
module tb_free_running_timer_counter;
    import frt_pkg::*;
    logic clk = 1'b0;
    logic rst = 1'b1;
    access_t acs = '0;
    timer_cfg_t cfg = '0;
    logic mask = 1'b0;
    logic halt = 1'b0;
    logic run = 1'b0;
    wire pin;
    logic [7:0] rd;
    logic [15:0] cnt;
    logic flag, tick, irq;
    logic [15:0] cnt_b;
    int failures = 0;
    int n_compared = 0;
    always #12.5 clk = ~clk;
    frt_ext_clock_src SRC (.clk(clk), .run(run), .pin(pin));
    free_running_timer_counter DUT (.clk(clk), .rst(rst), .access(acs), .cfg(cfg),
        .cpu_irq_mask(mask), .halt_mode(halt), .ext_timer_clock_pin(pin), .rdata(rd),
        .count_value(cnt), .wrap_flag(flag), .timer_tick(tick), .wrap_irq(irq));
    free_running_timer_counter #(.ext_pin_bonded(1'b0)) DUT_B (.clk(clk), .rst(rst),
        .access(acs), .cfg(cfg), .cpu_irq_mask(mask), .halt_mode(halt),
        .ext_timer_clock_pin(pin), .rdata(), .count_value(cnt_b), .wrap_flag(),
        .timer_tick(), .wrap_irq());
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        n_compared++;
        if (got !== exp)
        begin
            failures++;
            $display("unexpected at %0t: got %h want %h", $time, got, exp);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(negedge clk);
    endtask
    task automatic acc(input logic r, input logic w, input reg_sel_t s);
        acs = '{r, w, s};
        cyc(1);
        acs = '0;
        cyc(1);
    endtask
    task automatic print_verdict;
        $display("compared %0d failures %0d", n_compared, failures);
        if (failures == 0 && n_compared > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    task automatic t_reset;
        chk(cnt, 16'hFFFC);
        chk({8'h00, rd}, 16'h0000);
        cyc(1);
        chk(cnt, 16'hFFFC);
        chk({15'h0000, tick}, 16'h0001);
        cyc(3);
        chk(cnt, 16'hFFFE);
        $display("end reset");
    endtask
    task automatic t_div;
        for (int k = 0; k < 3; k++)
        begin
            cfg.clk_select_field = k[1:0];
            acc(1'b0, 1'b1, sel_count_low);
            cyc(31);
            chk(cnt, 16'hFFFC + (16'h0020 >> (k + 1)));
            chk(cnt_b, 16'hFFFC + (16'h0020 >> (k + 1)));
        end
        chk({15'h0000, flag}, 16'h0001);
        $display("end div");
    endtask
    task automatic t_flag;
        cfg.wrap_irq_enable = 1'b1;
        cyc(1);
        chk({15'h0000, irq}, 16'h0001);
        mask = 1'b1;
        cyc(1);
        chk({15'h0000, irq}, 16'h0000);
        mask = 1'b0;
        acc(1'b1, 1'b0, sel_alt_low);
        chk({15'h0000, flag}, 16'h0001);
        acc(1'b1, 1'b0, sel_count_low);
        chk({15'h0000, flag}, 16'h0001);
        acc(1'b1, 1'b0, sel_status);
        chk({8'h00, rd}, 16'h0020);
        acc(1'b1, 1'b0, sel_count_low);
        chk({15'h0000, flag}, 16'h0000);
        $display("end flag");
    endtask
    task automatic t_buffer;
        cfg.clk_select_field = clk_sel_div2;
        halt = 1'b1;
        acc(1'b0, 1'b1, sel_alt_low);
        acc(1'b1, 1'b0, sel_count_high);
        chk({8'h00, rd}, 16'h00FF);
        halt = 1'b0;
        cyc(16);
        halt = 1'b1;
        cyc(2);
        chk(cnt, 16'h0004);
        chk({15'h0000, tick}, 16'h0000);
        acc(1'b1, 1'b0, sel_alt_high);
        chk({8'h00, rd}, 16'h0000);
        acc(1'b1, 1'b0, sel_count_low);
        chk({8'h00, rd}, 16'h00FC);
        acc(1'b1, 1'b0, sel_alt_low);
        chk({8'h00, rd}, 16'h0004);
        halt = 1'b0;
        $display("end buffer");
    endtask
    task automatic t_ext;
        cfg.clk_select_field = clk_sel_ext;
        for (int e = 1; e >= 0; e--)
        begin
            cfg.ext_clk_edge_select = e[0];
            acc(1'b0, 1'b1, sel_count_low);
            run = 1'b1;
            cyc(20);
            run = 1'b0;
            cyc(8);
            chk(cnt, 16'hFFFF);
            chk(cnt_b, 16'hFFFC);
        end
        $display("end ext");
    endtask
    task automatic t_restart;
        cfg.clk_select_field = clk_sel_div2;
        halt = 1'b1;
        rst = 1'b1;
        cyc(2);
        chk(cnt, 16'hFFFC);
        chk({15'h0000, flag}, 16'h0000);
        halt = 1'b0;
        rst = 1'b0;
        cyc(1);
        chk(cnt, 16'hFFFC);
        cyc(1);
        chk(cnt, 16'hFFFD);
        $display("end restart");
    endtask
    initial
    begin
        cyc(12);
        rst = 1'b0;
        t_reset;
        t_div;
        t_flag;
        t_buffer;
        t_ext;
        t_restart;
        print_verdict;
    end
    initial
    begin
        cyc(5000);
        failures++;
        $display("unexpected at %0t: timeout", $time);
        print_verdict;
    end
endmodule
`default_nettype wire
